// ==== hdl/phy_event_regs.vh ====
/*
  Register offsets, bit positions and reset values of the event flag and
  PHY control register slice. Assumes inclusion by bare name.
*/
`ifndef PHY_EVENT_REGS_VH
`define PHY_EVENT_REGS_VH

`define ADDR_EVENT_FLAGS      5'h1b
`define ADDR_PHY_CONTROL_ONE  5'h1e
`define ADDR_PHY_CONTROL_TWO  5'h1f

`define EVENT_COUNT           8
`define EVENT_ENABLE_LSB      8

`define CTL1_MODE_MSB         15
`define CTL1_MODE_LSB         14
`define CTL1_POLARITY_BIT     13
`define CTL1_PAIR_STATE_BIT   11
`define CTL1_LOOPBACK_BIT     7

`define CTL2_ALGO_BIT         15
`define CTL2_MANUAL_PAIR_BIT  14
`define CTL2_XOVER_OFF_BIT    13
`define CTL2_IRQ_LEVEL_BIT    9

`define RST_ENABLES           8'h00
`define RST_MODE              2'h0
`define RST_LOOPBACK          1'h0
`define RST_ALGO              1'h1
`define RST_MANUAL_PAIR       1'h0
`define RST_XOVER_OFF         1'h0
`define RST_IRQ_LEVEL         1'h0

`define MODE_SPEED_LINKACT    2'h0
`define MODE_ACT_LINK         2'h1

`endif

// ==== hdl/event_flag_bit.v ====
/*
  One sticky event flag: set by a hardware event pulse, cleared when the
  register holding it is read. Assumes event and read pulse share clk.
*/
`timescale 1ns/1ps

module event_flag_bit (
  input  wire clk,        // System clock
  input  wire nrst,       // Async reset, active low
  input  wire event_in,   // Event pulse or level
  input  wire read_clear, // Register read strobe
  output reg  flag        // Sticky flag
);

  // Set wins over clear in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      flag <= 1'b0;
    else if (event_in)
      flag <= 1'b1;
    else if (read_clear)
      flag <= 1'b0;
  end

endmodule // event_flag_bit

// ==== hdl/phy_event_flags_and_control_regs.v ====
/*
  Event flag, enable and PHY control register slice of a 10/100 transceiver,
  reached through a simple synchronous register port fed by the management
  serial engine. Assumes event inputs are synchronous pulses on clk and that
  status inputs (polarity, link, speed, activity, auto pair state) come from
  logic on the same clock. Reserved indicator modes use the default mapping,
  and a flag whose event lands in the cycle of its read stays set.
*/
// What this block does
// - Jabber event flag latches 1, reads 0 otherwise, reset 0, clears on read.
// - Receive error flag sets on error, clears on read, reset 0.
// - Page received flag sets on arriving page, clears on read and reset.
// - Parallel detect fault flag sets on fault, clears on read and reset.
// - Partner acknowledge flag sets on acknowledge, clears on read and reset.
// - Link down flag sets on link loss, clears on read, reset 0.
// - Remote fault flag sets on remote fault, clears on read and reset.
// - Link up flag sets on link established, clears on read, reset 0.
// - Two-bit indicator mode, default 00, routes speed/link/activity to indicators.
// - Read-only bit reports reversed receive polarity as 1.
// - Loopback bit, default 0, enables remote analog loopback when 1.
// - Crossover algorithm select bit, default 1, picks detection algorithm.
// - With auto crossover off, manual bit fixes MDI (0) or MDI-X (1).
// - Each flag has an enable bit in upper byte, default 0.
// - Interrupt level bit, default 0, makes interrupt active high when 1.
// - Crossover disable bit, default 0, hands pairs to manual select.
`timescale 1ns/1ps
`include "phy_event_regs.vh"

module phy_event_flags_and_control_regs (
  input  wire        clk,                 // System clock, 20 MHz
  input  wire        nrst,                // Async reset, active low
  input  wire [4:0]  reg_addr,            // Register address
  input  wire        reg_write,           // Write strobe, one cycle
  input  wire [15:0] reg_wdata,           // Write data
  input  wire        reg_read,            // Read strobe, one cycle
  output reg  [15:0] reg_rdata,           // Read data, valid cycle after strobe
  input  wire [7:0]  event_in,            // Event pulses, bit order as flags
  input  wire        polarity_reversed,   // Detected receive polarity
  input  wire        auto_pair_swapped,   // Auto crossover result, 1 = MDI-X
  input  wire        link_ok,             // Link status
  input  wire        activity,            // Traffic activity
  input  wire        speed_100,           // Speed status
  output reg         indicator_a,         // Indicator output A
  output reg         indicator_b,         // Indicator output B
  output reg         remote_loopback,     // Remote analog loopback enable
  output reg         crossover_algo_select, // Crossover algorithm select
  output reg         pair_swapped,        // 1 = transmit on inbound pair
  output reg         irq_out             // Interrupt output, level per setting
);

  // ****************************************
  // Register decode
  // ****************************************
  reg  [7:0] enables;
  reg  [1:0] mode;
  reg        manual_pair;
  reg        xover_off;
  reg        irq_level;
  wire [7:0] flags;

  // Read strobe for the flag register, write strobe for each register
  wire rd_flags = reg_read && (reg_addr == `ADDR_EVENT_FLAGS);
  wire wr_flags = reg_write && (reg_addr == `ADDR_EVENT_FLAGS);
  wire wr_ctl1  = reg_write && (reg_addr == `ADDR_PHY_CONTROL_ONE);
  wire wr_ctl2  = reg_write && (reg_addr == `ADDR_PHY_CONTROL_TWO);

  // ****************************************
  // Interrupt enables, upper byte of flag register
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enables <= `RST_ENABLES;
    end else if (wr_flags) begin
      enables <= reg_wdata[`EVENT_ENABLE_LSB+7:`EVENT_ENABLE_LSB];
    end
  end

  // ****************************************
  // Control register one
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode            <= `RST_MODE;
      remote_loopback <= `RST_LOOPBACK;
    end else if (wr_ctl1) begin
      mode            <= reg_wdata[`CTL1_MODE_MSB:`CTL1_MODE_LSB];
      remote_loopback <= reg_wdata[`CTL1_LOOPBACK_BIT];
    end
  end

  // ****************************************
  // Control register two
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crossover_algo_select <= `RST_ALGO;
      manual_pair           <= `RST_MANUAL_PAIR;
      xover_off             <= `RST_XOVER_OFF;
      irq_level             <= `RST_IRQ_LEVEL;
    end else if (wr_ctl2) begin
      crossover_algo_select <= reg_wdata[`CTL2_ALGO_BIT];
      manual_pair           <= reg_wdata[`CTL2_MANUAL_PAIR_BIT];
      xover_off             <= reg_wdata[`CTL2_XOVER_OFF_BIT];
      irq_level             <= reg_wdata[`CTL2_IRQ_LEVEL_BIT];
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  // One sticky flag per event, cleared by a read of the register unless its event lands in the same cycle
  genvar i;
  generate
    for (i = 0; i < `EVENT_COUNT; i = i + 1) begin : g_flag
      event_flag_bit u_flag (
        .clk        (clk),
        .nrst       (nrst),
        .event_in   (event_in[i]),
        .read_clear (rd_flags),
        .flag       (flags[i])
      );
    end
  endgenerate

  // ****************************************
  // Pair assignment
  // ****************************************
  // Manual select only counts once auto crossover is off
  wire pair_now = xover_off ? manual_pair : auto_pair_swapped;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pair_swapped <= 1'b0;
    end else begin
      pair_swapped <= pair_now;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Captured only on a read, so the word stands until the next one
  reg  [15:0] next_rdata;

  always @* begin
    next_rdata = 16'h0000;
    if (reg_addr == `ADDR_EVENT_FLAGS) begin
      next_rdata = {enables, flags};
    end else if (reg_addr == `ADDR_PHY_CONTROL_ONE) begin
      next_rdata[`CTL1_MODE_MSB:`CTL1_MODE_LSB] = mode;
      next_rdata[`CTL1_POLARITY_BIT]            = polarity_reversed;
      next_rdata[`CTL1_PAIR_STATE_BIT]          = pair_now;
      next_rdata[`CTL1_LOOPBACK_BIT]            = remote_loopback;
    end else if (reg_addr == `ADDR_PHY_CONTROL_TWO) begin
      next_rdata[`CTL2_ALGO_BIT]        = crossover_algo_select;
      next_rdata[`CTL2_MANUAL_PAIR_BIT] = manual_pair;
      next_rdata[`CTL2_XOVER_OFF_BIT]   = xover_off;
      next_rdata[`CTL2_IRQ_LEVEL_BIT]   = irq_level;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      reg_rdata <= 16'h0000;
    else if (reg_read)
      reg_rdata <= next_rdata;
  end

  // ****************************************
  // Indicator routing
  // ****************************************
  reg         next_indicator_a;
  reg         next_indicator_b;

  // Reserved modes fall back to the default mapping
  always @* begin
    next_indicator_a = link_ok & activity;
    next_indicator_b = speed_100;
    case (mode)
      `MODE_SPEED_LINKACT: begin
        next_indicator_a = link_ok & activity;
        next_indicator_b = speed_100;
      end
      `MODE_ACT_LINK: begin
        next_indicator_a = link_ok;
        next_indicator_b = activity;
      end
      default: begin
        next_indicator_a = link_ok & activity;
        next_indicator_b = speed_100;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indicator_a <= 1'b0;
      indicator_b <= 1'b0;
    end else begin
      indicator_a <= next_indicator_a;
      indicator_b <= next_indicator_b;
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  wire irq_active = |(flags & enables);
  wire next_irq   = irq_level ? irq_active : ~irq_active;

  // Reset value is inactive for the default active-low level
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_out <= 1'b1;
    end else begin
      irq_out <= next_irq;
    end
  end

endmodule // phy_event_flags_and_control_regs

// ==== tb/phy_regs_checker.sv ====
/* Port assertions of the event flag and control register slice.
   Assumes a bind onto the design top module. */
`timescale 1ns/1ps
module phy_regs_checker (
  input logic        clk, nrst, reg_write, reg_read, polarity_reversed,
  input logic        auto_pair_swapped, link_ok, activity, speed_100,
  input logic        indicator_a, indicator_b, remote_loopback,
  input logic        crossover_algo_select, pair_swapped, irq_out,
  input logic [4:0]  reg_addr,
  input logic [15:0] reg_wdata, reg_rdata,
  input logic [7:0]  event_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire r1b = reg_read && reg_addr == 5'h1b;
  wire w1e = reg_write && reg_addr == 5'h1e;
  wire w1f = reg_write && reg_addr == 5'h1f;
  wire w1b = reg_write && reg_addr == 5'h1b;
  property p_set;
    event_in != 8'h00 ##1 r1b |=> (reg_rdata[7:0] & $past(event_in, 2)) == $past(event_in, 2);
  endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clear;
    r1b ##1 r1b |=> reg_rdata[7:0] == $past(event_in, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_unmap;
    reg_read && reg_addr != 5'h1b && reg_addr < 5'h1e |=> reg_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_enab;
    w1b ##1 !w1b ##1 r1b |=> reg_rdata[15:8] == $past(reg_wdata[15:8], 3);
  endproperty
  a_enab: assert property (p_enab) else $error("enable readback");
  property p_ind;
    w1e ##2 ($stable(link_ok) && $stable(activity) && $stable(speed_100)) |->
      ($past(reg_wdata[15:14], 2) == 2'h1 ? (indicator_a == link_ok && indicator_b == activity)
      : (indicator_a == (link_ok && activity) && indicator_b == speed_100));
  endproperty
  a_ind: assert property (p_ind) else $error("indicator");
  property p_pol;
    reg_read && reg_addr == 5'h1e |=> reg_rdata[13] == $past(polarity_reversed);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity");
  property p_loop;
    w1e |=> remote_loopback == $past(reg_wdata[7]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback");
  property p_algo;
    w1f |=> crossover_algo_select == $past(reg_wdata[15]);
  endproperty
  a_algo: assert property (p_algo) else $error("algo");
  property p_pair;
    w1f && reg_wdata[13] |-> ##2 pair_swapped == $past(reg_wdata[14], 2);
  endproperty
  a_pair: assert property (p_pair) else $error("pair");
  c_clear: cover property (r1b ##1 r1b);
  c_ind: cover property (w1e && reg_wdata[15:14] == 2'h1);
  c_pair: cover property (w1f && reg_wdata[14]);
  c_irq: cover property ($fell(irq_out));
endmodule // phy_regs_checker
bind phy_event_flags_and_control_regs phy_regs_checker u_chk (.*);

// ==== tb/mgmt_master.sv ====
/* Station management side: register write and read cycles.
   Assumes the design samples strobes at the rising clock edge. */
`timescale 1ns/1ps
module mgmt_master (
  input  logic        clk,       // System clock
  input  logic [15:0] reg_rdata, // Read data
  output logic [4:0]  reg_addr,  // Address
  output logic        reg_write, // Write strobe
  output logic [15:0] reg_wdata, // Write data
  output logic        reg_read   // Read strobe
);
  initial {reg_addr, reg_write, reg_wdata, reg_read} = 0;
  task wr(input [4:0] a, input [15:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clk); reg_write <= 1'b0; reg_wdata <= ~d;
  endtask
  task rd(input [4:0] a, input int n, output [15:0] d);
    @(posedge clk); reg_addr <= a; reg_read <= 1'b1;
    repeat (n) @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // mgmt_master

// ==== tb/phy_event_flags_and_control_regs_tb_top.sv ====
/* Self-checking bench of the register slice.
   Assumes the management model drives every register cycle. */
`timescale 1ns/1ps
module phy_event_flags_and_control_regs_tb_top;
  logic clk = 0, nrst = 0, pol = 1, lnk = 1, act = 0, spd = 1, aps = 0;
  logic [7:0] ev = 0;
  logic [4:0] a; logic w, r; logic [15:0] wd, rdv, d;
  logic ia, ib, lb, al, ps, irq;
  int n_mismatch = 0, checks_done = 0;
  always #25 clk = ~clk;
  mgmt_master u_mgmt_master (.clk(clk), .reg_rdata(rdv), .reg_addr(a), .reg_write(w),
    .reg_wdata(wd), .reg_read(r));
  phy_event_flags_and_control_regs u_phy_event_flags_and_control_regs (.clk(clk),
    .nrst(nrst), .reg_addr(a), .reg_write(w), .reg_wdata(wd), .reg_read(r), .reg_rdata(rdv),
    .event_in(ev), .polarity_reversed(pol), .auto_pair_swapped(aps), .link_ok(lnk),
    .activity(act), .speed_100(spd), .indicator_a(ia), .indicator_b(ib),
    .remote_loopback(lb), .crossover_algo_select(al), .pair_swapped(ps), .irq_out(irq));
  task chk(input [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %0t got %h exp %h", $time, g, e);
    end
  endtask
  task complete_run;
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task t_reset;
    u_mgmt_master.rd(5'h1e, 1, d); chk(d, 16'h2000);
    u_mgmt_master.rd(5'h1f, 1, d); chk(d, 16'h8000);
    u_mgmt_master.rd(5'h1c, 1, d); chk(d, 16'h0000);
    u_mgmt_master.rd(5'h1b, 1, d); chk(d, 16'h0000);
    chk({al, irq, lb, ps}, 4'hc);
  endtask
  task t_events;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk); ev <= 8'h01 << i;
      @(posedge clk); ev <= 8'h00;
      u_mgmt_master.rd(5'h1b, 1, d); chk(d, 16'h0001 << i);
      u_mgmt_master.rd(5'h1b, 1, d); chk(d, 16'h0000);
    end
    fork
      u_mgmt_master.rd(5'h1b, 2, d);
      begin @(posedge clk); ev <= 8'h81; @(posedge clk); ev <= 8'h00; end
    join
    chk(d, 16'h0081);
  endtask
  task t_irq;
    u_mgmt_master.wr(5'h1b, 16'h0400);
    u_mgmt_master.rd(5'h1b, 1, d); chk(d, 16'h0400);
    @(posedge clk); ev <= 8'h04;
    @(posedge clk); ev <= 8'h00;
    @(posedge clk); #1 chk(irq, 1'b0);
    u_mgmt_master.rd(5'h1b, 1, d); chk(d, 16'h0404);
    repeat (2) @(posedge clk); #1 chk(irq, 1'b1);
    @(posedge clk); ev <= 8'h01;
    @(posedge clk); ev <= 8'h00;
    @(posedge clk); #1 chk(irq, 1'b1);
    u_mgmt_master.rd(5'h1b, 1, d); chk(d, 16'h0401);
    u_mgmt_master.wr(5'h1f, 16'h8200);
    repeat (2) @(posedge clk); #1 chk(irq, 1'b0);
    @(posedge clk); ev <= 8'h04;
    @(posedge clk); ev <= 8'h00;
    @(posedge clk); #1 chk(irq, 1'b1);
    u_mgmt_master.rd(5'h1b, 1, d); chk(d, 16'h0404);
    repeat (2) @(posedge clk); #1 chk(irq, 1'b0);
  endtask
  task t_ctrl;
    u_mgmt_master.wr(5'h1e, 16'h7fff);
    repeat (2) @(posedge clk); #1 chk({lb, ia, ib}, 3'h6);
    u_mgmt_master.rd(5'h1e, 1, d); chk(d, 16'h6080);
    u_mgmt_master.wr(5'h1e, 16'h4000);
    u_mgmt_master.wr(5'h1e, 16'h0000);
    repeat (2) @(posedge clk); #1 chk({ia, ib}, 2'h1);
    @(posedge clk); act <= 1'b1; pol <= 1'b0;
    repeat (2) @(posedge clk); #1 chk({lb, ia, ib}, 3'h3);
    u_mgmt_master.rd(5'h1e, 1, d); chk(d, 16'h0000);
    u_mgmt_master.wr(5'h1f, 16'h6000);
    repeat (2) @(posedge clk); #1 chk({ps, al}, 2'h2);
    u_mgmt_master.rd(5'h1f, 1, d); chk(d, 16'h6000);
    @(posedge clk); aps <= 1'b1;
    u_mgmt_master.wr(5'h1f, 16'h2000);
    repeat (2) @(posedge clk); #1 chk(ps, 1'b0);
    u_mgmt_master.wr(5'h1f, 16'h0000);
    repeat (2) @(posedge clk); #1 chk(ps, 1'b1);
    u_mgmt_master.rd(5'h1e, 1, d); chk(d, 16'h0800);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_events;
    t_irq;
    t_ctrl;
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule // phy_event_flags_and_control_regs_tb_top
